// ==== pkg/adc_frame_pkg.sv ====
`default_nettype none
package adc_frame_pkg;

    // ==========================================================
    // Widths and sizes
    localparam int DATA_W       = 8;
    localparam int CNT_W        = 6;
    localparam int FIFO_DEPTH   = 32;
    localparam int ACQ_W        = 6;

    // ==========================================================
    // Serial clock falling-edge marks within a frame
    localparam logic [CNT_W-1:0] PWR_CAL_EDGES  = 6'h10;
    localparam logic [CNT_W-1:0] DATA_EDGES     = 6'h0A;
    localparam logic [CNT_W-1:0] CAL_START_EDGE = 6'h11;
    localparam logic [CNT_W-1:0] CAL_END_EDGE   = 6'h20;
    localparam logic [CNT_W-1:0] CNT_MAX        = 6'h3F;
    localparam logic [CNT_W-1:0] CNT_ZERO       = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE        = 6'h01;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int ACQ_NS        = 275;
    localparam int ACQ_CYCLES    = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [ACQ_W-1:0] ACQ_LOAD = ACQ_W'(ACQ_CYCLES);
    localparam logic [ACQ_W-1:0] ACQ_ZERO = 6'h00;
    localparam logic [ACQ_W-1:0] ACQ_ONE  = 6'h01;

    // ==========================================================
    // Reset values and codes
    localparam logic [DATA_W-1:0] STORE_CLR  = 8'h00;
    localparam logic [DATA_W-1:0] CODE_MIN   = 8'h00;
    localparam logic [DATA_W-1:0] CODE_MAX   = 8'hFF;
    localparam logic [DATA_W+1:0] SHIFT_IDLE = 10'h000;
    localparam logic [1:0]        LEAD_ZEROS = 2'h0;

    typedef enum logic [2:0] {
        FS_IDLE,
        FS_PWR_CAL,
        FS_CONVERT,
        FS_NORM_CAL,
        FS_DONE
    } frame_mode_t;

    // Raw code minus signed offset, clamped to the straight-binary range
    function automatic logic [DATA_W-1:0] sat_sub(input logic [DATA_W-1:0] raw,
                                                  input logic [DATA_W-1:0] ofs);
        logic signed [DATA_W+1:0] diff;
        diff = $signed({2'b00, raw}) - $signed({{2{ofs[DATA_W-1]}}, ofs});
        if (diff < 0) begin
            sat_sub = CODE_MIN;
        end else if (diff > $signed({2'b00, CODE_MAX})) begin
            sat_sub = CODE_MAX;
        end else begin
            sat_sub = diff[DATA_W-1:0];
        end
    endfunction : sat_sub

endpackage : adc_frame_pkg
`default_nettype wire

// ==== pkg/sample_stream_if.sv ====
`default_nettype none
interface sample_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport tx (output valid, output data, input ready);
    modport rx (input valid, input data, output ready);
endinterface : sample_stream_if
`default_nettype wire

// ==== core/sample_fifo.sv ====
`default_nettype none
module sample_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    input  wire logic     core_clk_in,
    input  wire logic     resetn_in,
    sample_stream_if.rx   fill,
    sample_stream_if.tx   drain
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [PW:0]   count;
    } fifo_st_t;

    fifo_st_t     q;
    fifo_st_t     d;
    logic [W-1:0] mem [DEPTH];
    logic         push;
    logic         pop;

    assign fill.ready  = (q.count != (PW+1)'(DEPTH));
    assign drain.valid = (q.count != '0);
    assign drain.data  = mem[q.rptr];
    assign push        = fill.valid & fill.ready;
    assign pop         = drain.valid & drain.ready;

    // ==========================================================
    // Pointer and occupancy update
    always_comb begin
        d = q;
        if (push) begin
            d.wptr = (q.wptr == PW'(DEPTH - 1)) ? '0 : PW'(q.wptr + 1'b1);
        end
        if (pop) begin
            d.rptr = (q.rptr == PW'(DEPTH - 1)) ? '0 : PW'(q.rptr + 1'b1);
        end
        if (push && !pop) begin
            d.count = (PW+1)'(q.count + 1'b1);
        end else if (pop && !push) begin
            d.count = (PW+1)'(q.count - 1'b1);
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem[q.wptr] <= fill.data;
        end
    end

endmodule : sample_fifo
`default_nettype wire

// ==== core/adc_serial_frame_offset_cal.sv ====
`default_nettype none
// Behaviour
// - First chip-select fall after power-up starts calibration instead of a conversion.
// - Power-up calibration completes at the 16th serial clock fall within that frame.
// - Serial output stays low throughout the power-up calibration frame.
// - Power-up frame shorter than 16 falls leaves the correction store unchanged.
// - Later results are corrected by the stored offset and shifted out.
// - Normal-frame recalibration needs at least 32 serial clock falls in one frame.
// - First 10 serial clocks of a normal frame convert and shift the sample.
// - Normal-frame calibration runs from the 17th to the 32nd serial clock fall.
// - Output low from the 10th fall; released when chip-select rises.
// - Normal frame shorter than 32 falls leaves the correction store unchanged.
// - Any calibration needs at least 15 serial clock periods of open frame.
// - Leading zero at chip-select fall, another zero, then 8 bits MSB first.
// - Correction store clears at power-up and is not reachable over the port.
// - Results are straight binary, 00 lowest, 80 mid-scale, FF full scale.
module adc_serial_frame_offset_cal #(
    parameter int DATA_W     = adc_frame_pkg::DATA_W,
    parameter int FIFO_DEPTH = adc_frame_pkg::FIFO_DEPTH
) (
    input  wire logic              core_clk_in,
    input  wire logic              resetn_in,
    input  wire logic              cs_n_in,
    input  wire logic              sclk_in,
    input  wire logic              raw_valid_in,
    input  wire logic [DATA_W-1:0] raw_data_in,
    output logic                   raw_ready_out,
    input  wire logic [DATA_W-1:0] cal_offset_in,
    output logic                   sdo_out,
    output logic                   sdo_oe_n_out,
    output logic                   cal_busy_out,
    output logic                   acq_short_out
);

    typedef struct packed {
        logic [1:0]                          cs_sync;
        logic                                cs_prev;
        logic [1:0]                          sck_sync;
        logic                                sck_prev;
        logic                                first;
        adc_frame_pkg::frame_mode_t          mode;
        logic [adc_frame_pkg::CNT_W-1:0]     cnt;
        logic                                cal_busy;
        logic [DATA_W-1:0]                   offset_correction_store;
        logic [DATA_W+1:0]                   shift;
        logic                                oe_n;
        logic [adc_frame_pkg::ACQ_W-1:0]     acq_cnt;
        logic                                acq_short;
    } core_st_t;

    localparam core_st_t ST_RESET = '{
        cs_sync:   2'h3,
        cs_prev:   1'b1,
        sck_sync:  2'h0,
        sck_prev:  1'b0,
        first:     1'b1,
        mode:      adc_frame_pkg::FS_IDLE,
        cnt:       adc_frame_pkg::CNT_ZERO,
        cal_busy:  1'b0,
        offset_correction_store: adc_frame_pkg::STORE_CLR,
        shift:     adc_frame_pkg::SHIFT_IDLE,
        oe_n:      1'b1,
        acq_cnt:   adc_frame_pkg::ACQ_ZERO,
        acq_short: 1'b0
    };

    core_st_t                        q;
    core_st_t                        d;
    logic                            cs_fall;
    logic                            cs_rise;
    logic                            sck_fall;
    logic [adc_frame_pkg::CNT_W-1:0] cnt_next;

    sample_stream_if #(.W(DATA_W)) fill_if ();
    sample_stream_if #(.W(DATA_W)) drain_if ();

    // ==========================================================
    // Raw sample buffer between the converter core and the frame logic
    assign fill_if.valid = raw_valid_in;
    assign fill_if.data  = raw_data_in;
    assign raw_ready_out = fill_if.ready;

    sample_fifo #(
        .W     (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_sample_fifo (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .fill        (fill_if),
        .drain       (drain_if)
    );

    // One sample is taken per conversion frame, so the buffer fills under slow frames
    assign drain_if.ready = cs_fall & ~q.first;

    // ==========================================================
    // Pin edge detection after two-stage synchronisers
    assign cs_fall  = q.cs_prev & ~q.cs_sync[1];
    assign cs_rise  = ~q.cs_prev & q.cs_sync[1];
    assign sck_fall = q.sck_prev & ~q.sck_sync[1];
    assign cnt_next = (q.cnt == adc_frame_pkg::CNT_MAX) ? q.cnt
                      : adc_frame_pkg::CNT_W'(q.cnt + adc_frame_pkg::CNT_ONE);

    // ==========================================================
    // Frame sequencer
    always_comb begin
        d           = q;
        d.cs_sync   = {q.cs_sync[0], cs_n_in};
        d.cs_prev   = q.cs_sync[1];
        d.sck_sync  = {q.sck_sync[0], sclk_in};
        d.sck_prev  = q.sck_sync[1];
        d.acq_short = 1'b0;
        if (q.acq_cnt != adc_frame_pkg::ACQ_ZERO) begin
            d.acq_cnt = adc_frame_pkg::ACQ_W'(q.acq_cnt - adc_frame_pkg::ACQ_ONE);
        end
        if (cs_fall) begin
            d.cnt       = adc_frame_pkg::CNT_ZERO;
            d.oe_n      = 1'b0;
            d.acq_short = (q.acq_cnt != adc_frame_pkg::ACQ_ZERO);
            if (q.first) begin
                d.first    = 1'b0;
                d.mode     = adc_frame_pkg::FS_PWR_CAL;
                d.cal_busy = 1'b1;
                d.shift    = adc_frame_pkg::SHIFT_IDLE;
            end else begin
                d.mode = adc_frame_pkg::FS_CONVERT;
                if (drain_if.valid) begin
                    d.shift = {adc_frame_pkg::LEAD_ZEROS,
                               adc_frame_pkg::sat_sub(drain_if.data,
                                                      q.offset_correction_store)};
                end else begin
                    d.shift = adc_frame_pkg::SHIFT_IDLE;
                end
            end
        end else if (cs_rise) begin
            d.mode     = adc_frame_pkg::FS_IDLE;
            d.cal_busy = 1'b0;
            d.oe_n     = 1'b1;
            d.shift    = adc_frame_pkg::SHIFT_IDLE;
        end else if (sck_fall && q.mode != adc_frame_pkg::FS_IDLE) begin
            d.cnt   = cnt_next;
            d.shift = {q.shift[DATA_W:0], 1'b0};
            case (q.mode)
                adc_frame_pkg::FS_PWR_CAL: begin
                    if (cnt_next == adc_frame_pkg::PWR_CAL_EDGES) begin
                        d.offset_correction_store = cal_offset_in;
                        d.cal_busy = 1'b0;
                        d.mode     = adc_frame_pkg::FS_DONE;
                        d.acq_cnt  = adc_frame_pkg::ACQ_LOAD;
                    end
                end
                adc_frame_pkg::FS_CONVERT: begin
                    if (cnt_next == adc_frame_pkg::CAL_START_EDGE) begin
                        d.cal_busy = 1'b1;
                        d.mode     = adc_frame_pkg::FS_NORM_CAL;
                    end
                end
                adc_frame_pkg::FS_NORM_CAL: begin
                    if (cnt_next == adc_frame_pkg::CAL_END_EDGE) begin
                        d.offset_correction_store = cal_offset_in;
                        d.cal_busy = 1'b0;
                        d.mode     = adc_frame_pkg::FS_DONE;
                        d.acq_cnt  = adc_frame_pkg::ACQ_LOAD;
                    end
                end
                adc_frame_pkg::FS_DONE: begin
                    d.mode = adc_frame_pkg::FS_DONE;
                end
                default: begin
                    d.mode = adc_frame_pkg::FS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q <= ST_RESET;
        end else begin
            q <= d;
        end
    end

    assign sdo_out       = q.shift[DATA_W+1];
    assign sdo_oe_n_out  = q.oe_n;
    assign cal_busy_out  = q.cal_busy;
    assign acq_short_out = q.acq_short;

    // ==========================================================
    // Assertions
    property p_first_frame_cal;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (cs_fall && q.first) |=> (q.mode == adc_frame_pkg::FS_PWR_CAL && cal_busy_out);
    endproperty
    a_first_frame_cal: assert property (p_first_frame_cal)
        else $error("first frame did not start calibration");

    property p_pwr_cal_commit;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (sck_fall && !cs_rise && q.mode == adc_frame_pkg::FS_PWR_CAL
         && q.cnt == adc_frame_pkg::PWR_CAL_EDGES - adc_frame_pkg::CNT_ONE)
        |=> (q.offset_correction_store == $past(cal_offset_in) && !cal_busy_out);
    endproperty
    a_pwr_cal_commit: assert property (p_pwr_cal_commit)
        else $error("power-up calibration did not commit at 16th edge");

    property p_pwr_cal_low;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (q.mode == adc_frame_pkg::FS_PWR_CAL) |-> !sdo_out;
    endproperty
    a_pwr_cal_low: assert property (p_pwr_cal_low)
        else $error("output not low during power-up calibration");

    property p_pwr_short_keep;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (cs_rise && q.mode == adc_frame_pkg::FS_PWR_CAL)
        |=> $stable(q.offset_correction_store);
    endproperty
    a_pwr_short_keep: assert property (p_pwr_short_keep)
        else $error("short power-up frame changed correction store");

    property p_corrected_load;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (cs_fall && !q.first && drain_if.valid)
        |=> (q.shift[DATA_W-1:0]
             == adc_frame_pkg::sat_sub($past(drain_if.data),
                                       $past(q.offset_correction_store)));
    endproperty
    a_corrected_load: assert property (p_corrected_load)
        else $error("loaded result not offset corrected");

    property p_norm_cal_start;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (q.mode == adc_frame_pkg::FS_NORM_CAL
         && $past(q.mode) == adc_frame_pkg::FS_CONVERT)
        |-> (q.cnt == adc_frame_pkg::CAL_START_EDGE && cal_busy_out);
    endproperty
    a_norm_cal_start: assert property (p_norm_cal_start)
        else $error("normal calibration started at wrong edge");

    property p_tail_low;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (q.mode != adc_frame_pkg::FS_IDLE && q.cnt >= adc_frame_pkg::DATA_EDGES)
        |-> !sdo_out;
    endproperty
    a_tail_low: assert property (p_tail_low)
        else $error("output not low after 10th edge");

    property p_release;
        @(posedge core_clk_in) disable iff (!resetn_in)
        cs_rise |=> (sdo_oe_n_out && !cal_busy_out);
    endproperty
    a_release: assert property (p_release)
        else $error("output not released on chip-select rise");

    property p_norm_short_keep;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (cs_rise && (q.mode == adc_frame_pkg::FS_CONVERT
                     || q.mode == adc_frame_pkg::FS_NORM_CAL))
        |=> $stable(q.offset_correction_store);
    endproperty
    a_norm_short_keep: assert property (p_norm_short_keep)
        else $error("short normal frame changed correction store");

    property p_lead_zero;
        @(posedge core_clk_in) disable iff (!resetn_in)
        cs_fall |=> (!sdo_out && !sdo_oe_n_out) ##1 !sdo_out;
    endproperty
    a_lead_zero: assert property (p_lead_zero)
        else $error("leading zero missing");

    property p_cnt_restart;
        @(posedge core_clk_in) disable iff (!resetn_in)
        cs_fall |=> (q.cnt == adc_frame_pkg::CNT_ZERO);
    endproperty
    a_cnt_restart: assert property (p_cnt_restart)
        else $error("edge counter not restarted");

    property p_acq_flag;
        @(posedge core_clk_in) disable iff (!resetn_in)
        cs_fall |=> (acq_short_out == ($past(q.acq_cnt) != adc_frame_pkg::ACQ_ZERO));
    endproperty
    a_acq_flag: assert property (p_acq_flag)
        else $error("acquisition interval flag wrong at frame start");

    property p_norm_cal_commit;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (sck_fall && !cs_rise && q.mode == adc_frame_pkg::FS_NORM_CAL
         && cnt_next == adc_frame_pkg::CAL_END_EDGE)
        |=> (q.offset_correction_store == $past(cal_offset_in) && !cal_busy_out);
    endproperty
    a_norm_cal_commit: assert property (p_norm_cal_commit)
        else $error("normal calibration did not commit at 32nd edge");

    property p_store_only_commit;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (q.mode != adc_frame_pkg::FS_DONE)
        |=> ($stable(q.offset_correction_store) || q.mode == adc_frame_pkg::FS_DONE);
    endproperty
    a_store_only_commit: assert property (p_store_only_commit)
        else $error("correction store changed outside a calibration commit");

    property p_empty_gives_zero;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (cs_fall && !q.first && !drain_if.valid)
        |=> (q.shift == adc_frame_pkg::SHIFT_IDLE);
    endproperty
    a_empty_gives_zero: assert property (p_empty_gives_zero)
        else $error("empty buffer did not give a zero result");

endmodule : adc_serial_frame_offset_cal
`default_nettype wire

// ==== tb/host_model.sv ====
`default_nettype none
module host_model (
    output logic      cs_n_out,
    output logic      sclk_out,
    input  wire logic sdo_in,
    input  wire logic sdo_oe_n_in,
    input  wire logic busy_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Captured link state, index k holds the value after fall k
    logic sdo_bits  [0:40];
    logic busy_bits [0:40];
    logic oe_n_after;

    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b1;
    end

    // Serial clock idles high and stands still outside frames
    // 125 ns period keeps the clock below 12 MHz in every frame
    task automatic run_frame(input int falls, input int gap_ns);
        int k;
        cs_n_out <= 1'b0;
        #62.5;
        for (k = 0; k < falls; k++) begin
            sdo_bits[k]  = (sdo_oe_n_in === 1'b0) ? sdo_in : 1'bx;
            busy_bits[k] = busy_in;
            sclk_out <= 1'b0;
            #62.5;
            sclk_out <= 1'b1;
            #62.5;
        end
        sdo_bits[falls]  = (sdo_oe_n_in === 1'b0) ? sdo_in : 1'bx;
        busy_bits[falls] = busy_in;
        #10;
        cs_n_out <= 1'b1;
        #62.5;
        oe_n_after = sdo_oe_n_in;
        // A normal gap honours the acquisition interval before the next fall
        #(gap_ns);
    endtask : run_frame

endmodule : host_model
`default_nettype wire

// ==== tb/tb_adc_serial_frame_offset_cal.sv ====
`default_nettype none
module tb_adc_serial_frame_offset_cal;
    timeunit 1ns;
    timeprecision 100ps;

    logic       core_clk  = 1'b0;
    logic       resetn    = 1'b0;
    logic       raw_valid = 1'b0;
    logic [7:0] raw_data  = 8'h00;
    logic [7:0] cal_offset = 8'h00;
    logic       cs_n;
    logic       sclk;
    logic       raw_ready;
    logic       sdo;
    logic       sdo_oe_n;
    logic       cal_busy;
    logic       acq_short;
    int         acq_cnt     = 0;
    int         error_cnt   = 0;
    int         checks_done = 0;

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    adc_serial_frame_offset_cal u_dut (
        .core_clk_in   (core_clk),
        .resetn_in     (resetn),
        .cs_n_in       (cs_n),
        .sclk_in       (sclk),
        .raw_valid_in  (raw_valid),
        .raw_data_in   (raw_data),
        .raw_ready_out (raw_ready),
        .cal_offset_in (cal_offset),
        .sdo_out       (sdo),
        .sdo_oe_n_out  (sdo_oe_n),
        .cal_busy_out  (cal_busy),
        .acq_short_out (acq_short)
    );

    host_model u_host (
        .cs_n_out    (cs_n),
        .sclk_out    (sclk),
        .sdo_in      (sdo),
        .sdo_oe_n_in (sdo_oe_n),
        .busy_in     (cal_busy)
    );

    always @(posedge core_clk) begin
        if (acq_short === 1'b1) begin
            acq_cnt <= acq_cnt + 1;
        end
    end

    // ==========================================================
    // Shared helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        $display("checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    task automatic do_reset;
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask : do_reset

    task automatic push(input logic [7:0] d);
        @(posedge core_clk);
        raw_valid <= 1'b1;
        raw_data  <= d;
        @(negedge core_clk);
        while (raw_ready !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        raw_valid <= 1'b0;
    endtask : push

    task automatic set_offset(input logic [7:0] ofs);
        @(posedge core_clk);
        cal_offset <= ofs;
    endtask : set_offset

    function automatic logic zero_span(input int lo, input int hi);
        logic acc;
        acc = 1'b0;
        for (int k = lo; k <= hi; k++) acc = acc | u_host.sdo_bits[k];
        return acc;
    endfunction : zero_span

    // Runs a normal frame and judges framing, data byte and release
    task automatic read_frame(input int falls, input int gap, input logic [7:0] exp);
        logic [7:0] got;
        u_host.run_frame(falls, gap);
        for (int k = 0; k < 8; k++) got[7-k] = u_host.sdo_bits[k+2];
        check({6'h00, u_host.sdo_bits[0], u_host.sdo_bits[1]}, 8'h00);
        check(got, exp);
        check({7'h00, zero_span(10, falls)}, 8'h00);
        check({7'h00, u_host.oe_n_after}, 8'h01);
    endtask : read_frame

    // ==========================================================
    // Scenarios
    task automatic startup_trim_duration;
        int acq0;
        do_reset();
        set_offset(8'h05);
        push(8'h40);
        push(8'h10);
        push(8'h08);
        push(8'h0C);
        u_host.run_frame(16, 400);
        check({7'h00, zero_span(0, 16)}, 8'h00);
        check({7'h00, u_host.busy_bits[0]}, 8'h01);
        acq0 = acq_cnt;
        read_frame(10, 400, 8'h3B);
        check(8'(acq_cnt - acq0), 8'h00);
        set_offset(8'h10);
        read_frame(20, 400, 8'h0B);
        check({7'h00, u_host.busy_bits[16]}, 8'h00);
        check({7'h00, u_host.busy_bits[17]}, 8'h01);
        read_frame(32, 1, 8'h03);
        check({7'h00, u_host.busy_bits[32]}, 8'h00);
        acq0 = acq_cnt;
        read_frame(10, 400, 8'h00);
        check(8'(acq_cnt - acq0), 8'h01);
    endtask : startup_trim_duration

    task automatic t_short_first;
        do_reset();
        set_offset(8'h20);
        push(8'h80);
        u_host.run_frame(8, 400);
        check({7'h00, zero_span(0, 8)}, 8'h00);
        check({7'h00, u_host.busy_bits[0]}, 8'h01);
        read_frame(10, 400, 8'h80);
    endtask : t_short_first

    task automatic t_fifo;
        do_reset();
        set_offset(8'h00);
        u_host.run_frame(16, 400);
        for (int i = 0; i < 32; i++) push(8'(i * 7 + 3));
        @(negedge core_clk);
        check({7'h00, raw_ready}, 8'h00);
        for (int i = 0; i < 32; i++) read_frame(10, 300, 8'(i * 7 + 3));
        read_frame(10, 300, 8'h00);
    endtask : t_fifo

    initial begin
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        startup_trim_duration();
        t_short_first();
        t_fifo();
        results();
    end

    initial begin
        #500us;
        error_cnt++;
        results();
    end

endmodule : tb_adc_serial_frame_offset_cal
`default_nettype wire
